// ==== src/pmcs_regs.sv ====
// PCS management control/status registers with a management-port slave
`timescale 1ns/1ps
`default_nettype none
module pmcs_regs #(
	parameter bit TBI_BUILD = 1'b0 // Ten-bit-interface build instead of transceiver
) (
	input wire logic i_sys_clk, // System clock, 40 MHz
	input wire logic i_rstn, // Synchronous reset, active low
	input wire logic i_clk_locked, // Clock manager lock, asynchronous
	input wire logic i_mdc, // Management clock from the station
	input wire logic i_mdio, // Management data in, sampled on i_mdc
	output logic o_mdio_out, // Management data out
	output logic o_mdio_tri, // Low while this end drives the data line
	input wire logic [4:0] i_phy_addr, // Own physical address strap
	input wire logic i_an_complete, // Auto-negotiation finished
	input wire logic i_remote_fault, // Remote fault seen
	input wire logic i_link_up, // Present link state
	output logic o_core_reset, // Soft core reset in progress
	output logic o_loopback, // Internal loopback request
	output logic o_ext_loopback, // External loopback request, ten-bit build
	output logic o_an_enable, // Auto-negotiation enabled
	output logic o_an_restart, // One-cycle restart pulse
	output logic o_power_down, // Transceiver low-power request
	output logic o_isolate, // Isolate from client interface
	output logic o_unidir_tx // Transmit regardless of link
);
	import pmcs_pkg::*;

	// Management clock domain
	logic mrst1_q, mrst2_q;
	logic [4:0] ph1_q, ph2_q;
	// Published by the system side, declared here because both domains use them
	logic sreq_q, sreq_d;
	logic [15:0] ctl_pub_q, ctl_pub_d, stat_pub_q, stat_pub_d;
	logic sreq1_q, sreq2_q, sreq3_q;
	pmcs_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d, rsh_q, rsh_d;
	logic [4:0] regad_q, regad_d;
	logic rd_q, rd_d, hit_q, hit_d;
	logic out_q, out_d, tri_q, tri_d;
	logic wtog_q, wtog_d, rtog_q, rtog_d;
	logic [4:0] waddr_q, waddr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [31:0] snap_q, snap_d;
	logic [15:0] rd_word;
	logic [15:0] sh_in;

	always_comb begin
		sh_in = {sh_q[14:0], i_mdio};
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_in;
		rsh_d = rsh_q;
		regad_d = regad_q;
		rd_d = rd_q;
		hit_d = hit_q;
		out_d = out_q;
		tri_d = tri_q;
		wtog_d = wtog_q;
		rtog_d = rtog_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		snap_d = snap_q;
		// Word handshake: capture the published snapshot when its request toggles
		if (sreq2_q != sreq3_q) begin
			snap_d = {ctl_pub_q, stat_pub_q};
		end
		// Undefined addresses read zero
		if (regad_q == REG_CTRL) begin
			rd_word = snap_q[31:16];
		end else if (regad_q == REG_STAT) begin
			rd_word = snap_q[15:0];
		end else begin
			rd_word = '0;
		end
		case (st_q)
			// A start bit may follow idle directly, so preamble is optional
			ST_IDLE: begin
				tri_d = 1'b1;
				if (!i_mdio) begin
					st_d = ST_START;
				end
			end
			ST_START: begin
				cnt_d = '0;
				st_d = i_mdio ? ST_OP : ST_IDLE;
			end
			ST_OP: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == OP_BITS_LAST) begin
					cnt_d = '0;
					st_d = (sh_in[1:0] == OP_READ || sh_in[1:0] == OP_WRITE) ? ST_PHY : ST_IDLE;
				end
			end
			ST_PHY: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == ADDR_BITS_LAST) begin
					cnt_d = '0;
					st_d = ST_REG;
				end
			end
			ST_REG: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == ADDR_BITS_LAST) begin
					cnt_d = '0;
					st_d = ST_TA;
					regad_d = sh_in[REGAD_LSB +: 5];
					rd_d = (sh_in[OP_LSB +: 2] == OP_READ);
					hit_d = (sh_in[PHYAD_LSB +: 5] == ph2_q)
						|| (sh_in[PHYAD_LSB +: 5] == PHY_BROADCAST);
				end
			end
			ST_TA: begin
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == '0 && rd_q && hit_q) begin
					out_d = 1'b0;
					tri_d = 1'b0;
					rsh_d = rd_word;
					// Reading status clears its latched bits on the system side
					if (regad_q == REG_STAT) begin
						rtog_d = ~rtog_q;
					end
				end
				if (cnt_q == TA_BITS_LAST) begin
					cnt_d = '0;
					st_d = ST_DATA;
					if (rd_q && hit_q) begin
						out_d = rsh_q[15];
						rsh_d = {rsh_q[14:0], 1'b0};
					end
				end
			end
			ST_DATA: begin
				cnt_d = cnt_q + 4'h1;
				out_d = rsh_q[15];
				rsh_d = {rsh_q[14:0], 1'b0};
				if (cnt_q == DATA_BITS_LAST) begin
					cnt_d = '0;
					st_d = ST_IDLE;
					tri_d = 1'b1;
					if (!rd_q && hit_q) begin
						waddr_d = regad_q;
						wdata_d = sh_in;
						wtog_d = ~wtog_q;
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		if (!mrst2_q) begin
			st_d = ST_IDLE;
			cnt_d = '0;
			out_d = 1'b1;
			tri_d = 1'b1;
			wtog_d = 1'b0;
			rtog_d = 1'b0;
			hit_d = 1'b0;
			rd_d = 1'b0;
			regad_d = '0;
			snap_d = '0;
		end
	end

	always_ff @(posedge i_mdc) begin
		mrst1_q <= i_rstn;
		mrst2_q <= mrst1_q;
		ph1_q <= i_phy_addr;
		ph2_q <= ph1_q;
		sreq1_q <= mrst2_q & sreq_q;
		sreq2_q <= mrst2_q & sreq1_q;
		sreq3_q <= mrst2_q & sreq2_q;
		st_q <= st_d;
		cnt_q <= cnt_d;
		sh_q <= sh_d;
		rsh_q <= rsh_d;
		regad_q <= regad_d;
		rd_q <= rd_d;
		hit_q <= hit_d;
		out_q <= out_d;
		tri_q <= tri_d;
		wtog_q <= wtog_d;
		rtog_q <= rtog_d;
		waddr_q <= waddr_d;
		wdata_q <= wdata_d;
		snap_q <= snap_d;
	end

	assign o_mdio_out = out_q;
	assign o_mdio_tri = tri_q;

	// System clock domain
	logic lk1_q, lk2_q, w1_q, w2_q, w3_q, r1_q, r2_q, r3_q, a1_q, a2_q;
	logic loop_q, loop_d, anen_q, anen_d, pd_q, pd_d, iso_q, iso_d, uni_q, uni_d;
	logic sr_q, sr_d, rs_q, rs_d, rf_q, rf_d, ll_q, ll_d, anc_q, anc_d;
	logic [3:0] srcnt_q, srcnt_d;
	logic clr_all, wr_ev, rd_ev;
	logic [15:0] ctl_rd, stat_rd;

	always_comb begin
		wr_ev = w2_q ^ w3_q;
		rd_ev = r2_q ^ r3_q;
		clr_all = !i_rstn || !lk2_q || (sr_q && srcnt_q == '0);
		loop_d = loop_q;
		anen_d = anen_q;
		pd_d = pd_q;
		iso_d = iso_q;
		uni_d = uni_q;
		sr_d = sr_q;
		srcnt_d = srcnt_q;
		rs_d = 1'b0;
		anc_d = i_an_complete;
		// A new event wins over the clear made by a status read
		rf_d = rd_ev ? 1'b0 : rf_q;
		if (i_remote_fault) begin
			rf_d = 1'b1;
		end
		ll_d = rd_ev ? i_link_up : ll_q;
		if (!i_link_up) begin
			ll_d = 1'b0;
		end
		if (sr_q && srcnt_q != '0) begin
			srcnt_d = srcnt_q - 4'h1;
		end
		// Only the control address holds writable bits
		if (wr_ev && waddr_q == REG_CTRL) begin
			loop_d = wdata_q[C_LOOP];
			anen_d = wdata_q[C_AN_EN];
			iso_d = wdata_q[C_ISOLATE];
			uni_d = wdata_q[C_UNIDIR];
			rs_d = wdata_q[C_RESTART];
			if (wdata_q[C_PWR_DN]) begin
				pd_d = 1'b1;
			end
			if (wdata_q[C_RESET] && !sr_q) begin
				sr_d = 1'b1;
				srcnt_d = SOFT_RST_LAST;
			end
		end
		if (clr_all) begin
			loop_d = RST_LOOP;
			anen_d = RST_AN_EN;
			pd_d = RST_PWR_DN;
			iso_d = RST_ISOLATE;
			uni_d = RST_UNIDIR;
			sr_d = 1'b0;
			srcnt_d = '0;
			rs_d = 1'b0;
			rf_d = 1'b0;
			ll_d = 1'b0;
			anc_d = 1'b0;
		end
		// Fixed bits come from constants, so no write reaches them
		ctl_rd = CTRL_FIXED;
		ctl_rd[C_RESET] = sr_q;
		ctl_rd[C_LOOP] = loop_q;
		ctl_rd[C_AN_EN] = anen_q;
		ctl_rd[C_PWR_DN] = pd_q;
		ctl_rd[C_ISOLATE] = iso_q;
		ctl_rd[C_UNIDIR] = uni_q;
		stat_rd = STAT_FIXED;
		stat_rd[S_AN_DONE] = anc_q;
		stat_rd[S_RFAULT] = rf_q;
		stat_rd[S_LINK] = ll_q;
		// Republish only after the management side acknowledged the last word
		sreq_d = sreq_q;
		ctl_pub_d = ctl_pub_q;
		stat_pub_d = stat_pub_q;
		if (a2_q == sreq_q) begin
			sreq_d = ~sreq_q;
			ctl_pub_d = ctl_rd;
			stat_pub_d = stat_rd;
		end
		if (!i_rstn) begin
			sreq_d = 1'b0;
			ctl_pub_d = '0;
			stat_pub_d = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		lk1_q <= i_clk_locked;
		lk2_q <= lk1_q;
		w1_q <= i_rstn & wtog_q;
		w2_q <= i_rstn & w1_q;
		w3_q <= i_rstn & w2_q;
		r1_q <= i_rstn & rtog_q;
		r2_q <= i_rstn & r1_q;
		r3_q <= i_rstn & r2_q;
		a1_q <= i_rstn & sreq3_q;
		a2_q <= i_rstn & a1_q;
		sreq_q <= sreq_d;
		ctl_pub_q <= ctl_pub_d;
		stat_pub_q <= stat_pub_d;
		loop_q <= loop_d;
		anen_q <= anen_d;
		pd_q <= pd_d;
		iso_q <= iso_d;
		uni_q <= uni_d;
		sr_q <= sr_d;
		srcnt_q <= srcnt_d;
		rs_q <= rs_d;
		rf_q <= rf_d;
		ll_q <= ll_d;
		anc_q <= anc_d;
		o_core_reset <= sr_d;
		o_loopback <= loop_d & !TBI_BUILD;
		o_ext_loopback <= loop_d & TBI_BUILD;
		o_an_enable <= anen_d;
		o_an_restart <= rs_d;
		o_power_down <= pd_d & !TBI_BUILD;
		o_isolate <= iso_d;
		o_unidir_tx <= uni_d & !anen_d;
	end

	// Checks
	sequence s_soft_rst_start;
		$rose(sr_q);
	endsequence

	chk_soft_rst_len: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		s_soft_rst_start |-> sr_q[*8] ##1 !sr_q)
		else $error("soft reset length wrong");
	chk_soft_rst_dflt: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$fell(sr_q) |-> anen_q && iso_q && !loop_q && !pd_q && !uni_q)
		else $error("defaults not restored after soft reset");
	chk_restart_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_an_restart |=> !o_an_restart)
		else $error("restart not a single pulse");
	chk_unidir_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_unidir_tx |-> (o_an_enable == 1'b0) && uni_q)
		else $error("unidirectional transmit with autoneg on");
	chk_link_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!i_link_up ##1 !rd_ev [*2]) |-> !ll_q)
		else $error("link down not latched");
	chk_rfault_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_remote_fault |=> rf_q)
		else $error("remote fault lost");
	chk_pd_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		pd_q && !clr_all |=> pd_q)
		else $error("power down cleared without reset");
	chk_ctrl_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ctl_pub_q & 16'h21DF) == 16'h0140 || ctl_pub_q == '0)
		else $error("fixed control bits wrong");

	sequence s_read_hit;
		st_q == ST_REG && cnt_q == ADDR_BITS_LAST && sh_in[OP_LSB +: 2] == OP_READ
			&& sh_in[PHYAD_LSB +: 5] == PHY_BROADCAST;
	endsequence

	chk_ta_drive: assert property (@(posedge i_mdc) disable iff (!mrst2_q)
		s_read_hit |-> ##1 tri_q ##1 !tri_q [*8] ##1 !tri_q [*8] ##1 !tri_q ##1 tri_q)
		else $error("read turnaround drive wrong");
	chk_undef_zero: assert property (@(posedge i_mdc) disable iff (!mrst2_q)
		(st_q == ST_DATA && rd_q && hit_q && regad_q > REG_STAT) |-> !out_q)
		else $error("undefined address read nonzero");
endmodule : pmcs_regs
`default_nettype wire

// ==== inc/pmcs_pkg.sv ====
// Package for the PCS management control and status register pair
package pmcs_pkg;
	// Management frame fields
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [3:0] OP_BITS_LAST = 4'h1;
	localparam logic [3:0] ADDR_BITS_LAST = 4'h4;
	localparam logic [3:0] TA_BITS_LAST = 4'h1;
	localparam logic [3:0] DATA_BITS_LAST = 4'hF;
	localparam logic [4:0] PHY_BROADCAST = 5'h00;
	localparam int REGAD_LSB = 0;
	localparam int PHYAD_LSB = 5;
	localparam int OP_LSB = 10;
	// Register addresses
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h01;
	// Control bit positions
	localparam int C_RESET = 15;
	localparam int C_LOOP = 14;
	localparam int C_AN_EN = 12;
	localparam int C_PWR_DN = 11;
	localparam int C_ISOLATE = 10;
	localparam int C_RESTART = 9;
	localparam int C_UNIDIR = 5;
	// Status bit positions
	localparam int S_AN_DONE = 5;
	localparam int S_RFAULT = 4;
	localparam int S_LINK = 2;
	// Fixed read values: duplex and speed MSB in control, abilities in status
	localparam logic [15:0] CTRL_FIXED = 16'h0140;
	localparam logic [15:0] STAT_FIXED = 16'h01C8;
	// Reset values of the writable control bits
	localparam logic RST_LOOP = 1'b0;
	localparam logic RST_AN_EN = 1'b1;
	localparam logic RST_PWR_DN = 1'b0;
	localparam logic RST_ISOLATE = 1'b1;
	localparam logic RST_UNIDIR = 1'b0;
	// Last count of the soft core reset, which lasts 8 system clocks
	localparam logic [3:0] SOFT_RST_LAST = 4'h7;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_OP = 3'h3,
		ST_PHY = 3'h2,
		ST_REG = 3'h6,
		ST_TA = 3'h7,
		ST_DATA = 3'h5
	} pmcs_state_t;
endpackage : pmcs_pkg

// ==== testbench/pmcs_sta_model.sv ====
// Behavioural management station: clocks the link and frames reads and writes
`timescale 1ns/1ps
`default_nettype none
module pmcs_sta_model (
	output logic o_mdc, // Link clock, still except while a frame or an idle run clocks it
	output logic o_drv, // Data driven by the station
	output logic o_oe, // High while the station drives
	input wire logic i_mdio // Resolved data line
);
	import pmcs_pkg::*;
	initial begin
		o_mdc = 1'b0;
		o_drv = 1'b1;
		o_oe = 1'b0;
	end
	// Data changes just after the rise, line is sampled just before the next rise
	task automatic cyc(input logic b, input logic oe, output logic s);
		o_mdc = 1'b1;
		#1;
		o_drv = b;
		o_oe = oe;
		#15;
		o_mdc = 1'b0;
		#15;
		s = i_mdio;
		#1;
	endtask : cyc
	task automatic idle(input int n);
		logic s;
		repeat (n) cyc(1'b1, 1'b1, s);
	endtask : idle
	// Returns second turnaround bit and the 16 data bits
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
			input logic [15:0] wd, input int pre, output logic [16:0] rd);
		logic [31:0] bits;
		logic s;
		bits = {2'b01, op, phy, ra, 2'b10, wd};
		idle(pre);
		for (int i = 31; i >= 0; i--) begin
			cyc(bits[i], (op == OP_WRITE) || (i > 17), s);
			if (i <= 16)
				rd[i] = s;
		end
		// Extra edge lets the device take the last bit, then the line is released
		cyc(1'b1, 1'b0, s);
	endtask : frame
endmodule : pmcs_sta_model
`default_nettype wire

// ==== testbench/pmcs_regs_tb.sv ====
// Self-checking bench for the management control and status registers
`timescale 1ns/1ps
`default_nettype none
module pmcs_regs_tb;
	import pmcs_pkg::*;
	localparam logic [4:0] MY_PHY = 5'h05;
	logic i_sys_clk, i_rstn, i_clk_locked, i_an_complete, i_remote_fault, i_link_up;
	logic mdc, sta_drv, sta_oe, mdio_out, mdio_tri, mdio;
	logic c_rst, loop, ext_loop, an_en, an_rs, pd, iso, uni, t_loop, t_ext, t_pd;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int n_restart = 0;
	int n_creset = 0;
	logic [16:0] rv;
	// Pulled-up shared line
	assign mdio = !mdio_tri ? mdio_out : (sta_oe ? sta_drv : 1'b1);
	pmcs_sta_model u_sta (.o_mdc(mdc), .o_drv(sta_drv), .o_oe(sta_oe), .i_mdio(mdio));
	pmcs_regs #(.TBI_BUILD(1'b0)) dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
		.i_clk_locked(i_clk_locked), .i_mdc(mdc), .i_mdio(mdio), .o_mdio_out(mdio_out),
		.o_mdio_tri(mdio_tri), .i_phy_addr(MY_PHY), .i_an_complete(i_an_complete),
		.i_remote_fault(i_remote_fault), .i_link_up(i_link_up), .o_core_reset(c_rst),
		.o_loopback(loop), .o_ext_loopback(ext_loop), .o_an_enable(an_en),
		.o_an_restart(an_rs), .o_power_down(pd), .o_isolate(iso), .o_unidir_tx(uni));
	// Ten-bit build listens only; its data line output is left off the wire
	pmcs_regs #(.TBI_BUILD(1'b1)) u_tbi (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
		.i_clk_locked(i_clk_locked), .i_mdc(mdc), .i_mdio(mdio), .o_mdio_out(),
		.o_mdio_tri(), .i_phy_addr(MY_PHY), .i_an_complete(i_an_complete),
		.i_remote_fault(i_remote_fault), .i_link_up(i_link_up), .o_core_reset(),
		.o_loopback(t_loop), .o_ext_loopback(t_ext), .o_an_enable(), .o_an_restart(),
		.o_power_down(t_pd), .o_isolate(), .o_unidir_tx());
	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end
	// Pulse counters look at mid-cycle, away from the edge that launches the outputs
	always @(negedge i_sys_clk) begin
		cycles++;
		if (an_rs === 1'b1)
			n_restart++;
		if (c_rst === 1'b1)
			n_creset++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d,
			input int pre);
		logic [16:0] r;
		u_sta.frame(OP_WRITE, phy, ra, d, pre, r);
	endtask : wr
	task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
		logic [16:0] r;
		u_sta.frame(OP_READ, MY_PHY, ra, 16'h0000, 16, r);
		check(r, {1'b0, exp});
	endtask : rdc
	// Control outputs packed as reset, loop, ext loop, an, restart, power down, isolate, unidir
	task automatic outs(input logic [7:0] exp);
		@(posedge i_sys_clk);
		#1;
		check({9'h000, c_rst, loop, ext_loop, an_en, an_rs, pd, iso, uni}, {9'h000, exp});
	endtask : outs
	// Reset-like input held low while the link clock keeps running
	task automatic pulse_low(input bit lock);
		fork
			u_sta.idle(10);
			begin
				@(posedge i_sys_clk);
				#1;
				if (lock)
					i_clk_locked = 1'b0;
				else
					i_rstn = 1'b0;
				repeat (10) @(posedge i_sys_clk);
				#1;
				i_clk_locked = 1'b1;
				i_rstn = 1'b1;
			end
		join
	endtask : pulse_low
	initial begin
		i_rstn = 1'b0;
		i_clk_locked = 1'b1;
		i_an_complete = 1'b0;
		i_remote_fault = 1'b0;
		i_link_up = 1'b0;
		pulse_low(1'b0);
		outs(8'h12);
		rdc(REG_CTRL, 16'h1540);
		rdc(REG_STAT, 16'h01C8);
		wr(MY_PHY, REG_CTRL, 16'h6C3F, 16);
		rdc(REG_CTRL, 16'h4D60);
		outs(8'h47);
		check({14'h0000, t_loop, t_ext, t_pd}, 17'h00002);
		wr(MY_PHY, REG_CTRL, 16'h1020, 16);
		rdc(REG_CTRL, 16'h1960);
		outs(8'h14);
		n_restart = 0;
		wr(MY_PHY, REG_CTRL, 16'h1220, 16);
		rdc(REG_CTRL, 16'h1960);
		check(17'(n_restart), 17'h00001);
		wr(MY_PHY, REG_STAT, 16'hFFFF, 16);
		wr(MY_PHY, 5'h05, 16'hFFFF, 0);
		rdc(5'h05, 16'h0000);
		rdc(5'h1F, 16'h0000);
		rdc(REG_STAT, 16'h01C8);
		wr(5'h03, REG_CTRL, 16'h0000, 16);
		rdc(REG_CTRL, 16'h1960);
		u_sta.frame(OP_READ, 5'h03, REG_CTRL, 16'h0000, 16, rv);
		check(rv, 17'h1FFFF);
		u_sta.frame(OP_READ, PHY_BROADCAST, REG_CTRL, 16'h0000, 16, rv);
		check(rv, 17'h01960);
		i_link_up = 1'b1;
		i_an_complete = 1'b1;
		rdc(REG_STAT, 16'h01E8);
		rdc(REG_STAT, 16'h01EC);
		@(posedge i_sys_clk);
		#1;
		i_link_up = 1'b0;
		i_remote_fault = 1'b1;
		@(posedge i_sys_clk);
		#1;
		i_remote_fault = 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1;
		i_link_up = 1'b1;
		rdc(REG_STAT, 16'h01F8);
		rdc(REG_STAT, 16'h01EC);
		n_creset = 0;
		wr(MY_PHY, REG_CTRL, 16'h8000, 16);
		rdc(REG_CTRL, 16'h1540);
		check(17'(n_creset), 17'h00008);
		wr(MY_PHY, REG_CTRL, 16'h4000, 16);
		rdc(REG_CTRL, 16'h4140);
		pulse_low(1'b1);
		rdc(REG_CTRL, 16'h1540);
		outs(8'h12);
		final_report();
	end
endmodule : pmcs_regs_tb
`default_nettype wire
